// ===== cpsm_map.svh
// Offsets, field positions, reset values and timing counts of the cell protector
`ifndef CPSM_MAP_SVH
`define CPSM_MAP_SVH

`define CPSM_CLK_MHZ      125
`define CPSM_OV_DLY_US    2000
`define CPSM_UV_DLY_US    1000
`define CPSM_OV_DLY_CYC   (`CPSM_OV_DLY_US * `CPSM_CLK_MHZ)
`define CPSM_UV_DLY_CYC   (`CPSM_UV_DLY_US * `CPSM_CLK_MHZ)

`define CPSM_ADDR_W       8
`define CPSM_OFS_CTRL     8'h00
`define CPSM_OFS_STATUS   8'h04
`define CPSM_OFS_EVENT    8'h08
`define CPSM_RST_CTRL     1'h0

`define CPSM_CTRL_HOLD    0
`define CPSM_EVT_OV       0
`define CPSM_EVT_UV       1

`define CPSM_STS_OV       0
`define CPSM_STS_UV       1
`define CPSM_STS_WARN     2
`define CPSM_STS_SLEEP    3
`define CPSM_STS_CHG      4
`define CPSM_STS_DIS      5
`define CPSM_STS_HOLD     6
`define CPSM_STS_PINS     8

`define CPSM_NPINS        10
`define CPSM_PIN_OVH      0
`define CPSM_PIN_OVR      2
`define CPSM_PIN_UVL      4
`define CPSM_PIN_WRN      6
`define CPSM_PIN_CHG      8
`define CPSM_PIN_HLD      9

`endif

// ===== cpsm_pkg.sv
// Types shared by the cell protector modules
`include "cpsm_map.svh"
`default_nettype none
package cpsm_pkg;
    typedef enum logic [1:0] {
        cpsm_normal, cpsm_over, cpsm_under, cpsm_both
    } cpsm_mode_t;

    typedef struct packed {
        logic [31:0] cnt;
        logic        hit;
    } cpsm_qual_st_t;

    typedef struct packed {
        logic [`CPSM_NPINS-1:0] sync1;
        logic [`CPSM_NPINS-1:0] sync2;
        cpsm_mode_t             mode;
        logic                   sleep;
        logic                   hold;
        logic                   high_n;
        logic                   low_n;
        logic                   warn;
        logic                   chg_en;
        logic                   dis_en;
        logic                   sw_hold;
        logic                   ov_evt;
        logic                   uv_evt;
        logic [31:0]            rd_data;
    } cpsm_top_st_t;
endpackage
`default_nettype wire

// ===== cpsm_qual_if.sv
// Condition and qualified result between protector and its delay filter
`default_nettype none
interface cpsm_qual_if;
    logic cond;
    logic hit;
    modport qual (input cond, output hit);
    modport user (output cond, input hit);
endinterface
`default_nettype wire

// ===== cpsm_qual.sv
// Persistence filter: a condition must hold a full count before it counts
`include "cpsm_map.svh"
`default_nettype none
module cpsm_qual #(
    parameter int unsigned DLY_CYC = `CPSM_UV_DLY_CYC
) (
    input  wire logic     clk,
    input  wire logic     srst,
    cpsm_qual_if.qual     qif
);
    if (DLY_CYC < 1) begin : g_bad_dly
        $error("cpsm_qual: DLY_CYC must be at least one");
    end

    localparam logic [31:0] LAST = 32'(DLY_CYC - 1);

    cpsm_pkg::cpsm_qual_st_t s_r;
    cpsm_pkg::cpsm_qual_st_t s_nxt;

    always_comb begin
        s_nxt = s_r;
        if (!qif.cond) begin
            s_nxt.cnt = 32'h0;
            s_nxt.hit = 1'b0;
        end else if (s_r.cnt == LAST) begin
            s_nxt.hit = 1'b1;
        end else begin
            s_nxt.cnt = s_r.cnt + 32'h1;
        end
    end

    always_ff @(posedge clk) begin
        if (srst) begin
            s_r <= '0;
        end else begin
            s_r <= s_nxt;
        end
    end

    assign qif.hit = s_r.hit;

    a_qual_gap_clears: assert property (
        @(posedge clk) disable iff (srst)
        !qif.cond |=> !qif.hit) else $error("hit survived a gap");
    a_qual_full_run: assert property (
        @(posedge clk) disable iff (srst)
        $rose(qif.hit) |-> $past(s_r.cnt) == LAST && $past(qif.cond))
        else $error("hit rose before the full count");
endmodule // cpsm_qual
`default_nettype wire

// ===== cpsm_top.sv
// Two-cell protection state machine with its register port
//
// Our own choices: the address map and the address-and-strobe port.
`include "cpsm_map.svh"
`default_nettype none
module cpsm_top #(
    parameter int unsigned OV_DLY_CYC = `CPSM_OV_DLY_CYC,
    parameter int unsigned UV_DLY_CYC = `CPSM_UV_DLY_CYC
) (
    input  wire logic                    clk,
    input  wire logic                    srst,
    input  wire logic [1:0]              cell_above_ov,
    input  wire logic [1:0]              cell_below_ovr,
    input  wire logic [1:0]              cell_below_uv,
    input  wire logic [1:0]              cell_below_warn,
    input  wire logic                    charger_seen,
    input  wire logic                    assembly_hold,
    input  wire logic [`CPSM_ADDR_W-1:0] reg_addr,
    input  wire logic [31:0]             reg_wr_data,
    input  wire logic                    reg_wr_en,
    input  wire logic                    reg_rd_en,
    output logic      [31:0]             reg_rd_data,
    output logic                         high_cell_flag_n,
    output logic                         low_cell_flag_n,
    output logic                         charge_soon_warning,
    output logic                         charge_path_en,
    output logic                         discharge_path_en,
    output logic                         sleep_mode
);
    if (OV_DLY_CYC < 1 || UV_DLY_CYC < 1) begin : g_bad_dly
        $error("cpsm_top: qualification counts must be at least one");
    end

    // Hold reads as set until the pin has crossed both flops,
    // so the switch cannot blink on while the pins settle
    localparam logic [`CPSM_NPINS-1:0] PINS_RST =
        `CPSM_NPINS'(1) << `CPSM_PIN_HLD;

    localparam cpsm_pkg::cpsm_top_st_t RST = '{
        sync1   : PINS_RST,
        sync2   : PINS_RST,
        mode    : cpsm_pkg::cpsm_normal,
        sleep   : 1'b0,
        hold    : 1'b1,
        high_n  : 1'b1,
        low_n   : 1'b1,
        warn    : 1'b0,
        chg_en  : 1'b0,
        dis_en  : 1'b0,
        sw_hold : `CPSM_RST_CTRL,
        ov_evt  : 1'b0,
        uv_evt  : 1'b0,
        rd_data : '0
    };

    cpsm_pkg::cpsm_top_st_t s_r;
    cpsm_pkg::cpsm_top_st_t s_nxt;

    cpsm_qual_if ov_if ();
    cpsm_qual_if uv_if ();

    logic [`CPSM_NPINS-1:0] pins;
    logic                   any_ov;
    logic                   any_uv;
    logic                   all_ovr;
    logic                   any_warn;
    logic                   charger;
    logic                   ov_bit;
    logic                   uv_bit;

    function automatic logic is_ov(input cpsm_pkg::cpsm_mode_t m);
        return m == cpsm_pkg::cpsm_over || m == cpsm_pkg::cpsm_both;
    endfunction

    function automatic logic is_uv(input cpsm_pkg::cpsm_mode_t m);
        return m == cpsm_pkg::cpsm_under || m == cpsm_pkg::cpsm_both;
    endfunction

    assign pins = {assembly_hold, charger_seen, cell_below_warn,
                   cell_below_uv, cell_below_ovr, cell_above_ov};

    // Comparator levels are only ever read after the second flop
    assign any_ov   = |s_r.sync2[`CPSM_PIN_OVH +: 2];
    assign any_uv   = |s_r.sync2[`CPSM_PIN_UVL +: 2];
    assign all_ovr  = &s_r.sync2[`CPSM_PIN_OVR +: 2];
    assign any_warn = |s_r.sync2[`CPSM_PIN_WRN +: 2];
    assign charger  = s_r.sync2[`CPSM_PIN_CHG];

    assign ov_if.cond = any_ov;
    assign uv_if.cond = any_uv;

    cpsm_qual #(
        .DLY_CYC (OV_DLY_CYC)
    ) u_ov_qual (
        .clk  (clk),
        .srst (srst),
        .qif  (ov_if.qual)
    );

    cpsm_qual #(
        .DLY_CYC (UV_DLY_CYC)
    ) u_uv_qual (
        .clk  (clk),
        .srst (srst),
        .qif  (uv_if.qual)
    );

    always_comb begin
        s_nxt       = s_r;
        s_nxt.sync1 = pins;
        s_nxt.sync2 = s_r.sync1;

        s_nxt.hold = s_r.sync2[`CPSM_PIN_HLD] | s_r.sw_hold;

        unique case (s_r.mode)
            cpsm_pkg::cpsm_normal: begin
                if (ov_if.hit && uv_if.hit) begin
                    s_nxt.mode = cpsm_pkg::cpsm_both;
                end else if (ov_if.hit) begin
                    s_nxt.mode = cpsm_pkg::cpsm_over;
                end else if (uv_if.hit) begin
                    s_nxt.mode = cpsm_pkg::cpsm_under;
                end
            end
            cpsm_pkg::cpsm_over: begin
                if (uv_if.hit) begin
                    s_nxt.mode = cpsm_pkg::cpsm_both;
                end else if (all_ovr) begin
                    s_nxt.mode = cpsm_pkg::cpsm_normal;
                end
            end
            cpsm_pkg::cpsm_under: begin
                if (ov_if.hit) begin
                    s_nxt.mode = cpsm_pkg::cpsm_both;
                end else if (!any_warn) begin
                    s_nxt.mode = cpsm_pkg::cpsm_normal;
                end
            end
            cpsm_pkg::cpsm_both: begin
                // Each half recovers on its own threshold
                if (all_ovr && !any_warn) begin
                    s_nxt.mode = cpsm_pkg::cpsm_normal;
                end else if (all_ovr) begin
                    s_nxt.mode = cpsm_pkg::cpsm_under;
                end else if (!any_warn) begin
                    s_nxt.mode = cpsm_pkg::cpsm_over;
                end
            end
        endcase

        ov_bit = is_ov(s_nxt.mode);
        uv_bit = is_uv(s_nxt.mode);

        s_nxt.high_n = !ov_bit;
        s_nxt.low_n  = !uv_bit;
        s_nxt.warn   = any_warn && !uv_bit;
        s_nxt.chg_en = !s_nxt.hold && !ov_bit;
        s_nxt.dis_en = !s_nxt.hold && !uv_bit;

        if (uv_bit && !is_uv(s_r.mode)) begin
            s_nxt.sleep = 1'b1;
        end else if (!uv_bit || charger) begin
            s_nxt.sleep = 1'b0;
        end

        // Write one to clear; a new entry in the same cycle still sets
        if (reg_wr_en && reg_addr == `CPSM_OFS_EVENT) begin
            s_nxt.ov_evt = s_r.ov_evt & ~reg_wr_data[`CPSM_EVT_OV];
            s_nxt.uv_evt = s_r.uv_evt & ~reg_wr_data[`CPSM_EVT_UV];
        end
        if (ov_bit && !is_ov(s_r.mode)) begin
            s_nxt.ov_evt = 1'b1;
        end
        if (uv_bit && !is_uv(s_r.mode)) begin
            s_nxt.uv_evt = 1'b1;
        end

        if (reg_wr_en && reg_addr == `CPSM_OFS_CTRL) begin
            s_nxt.sw_hold = reg_wr_data[`CPSM_CTRL_HOLD];
        end

        // Read data stands for one cycle only; unmapped reads return zero
        s_nxt.rd_data = 32'h0;
        if (reg_rd_en) begin
            unique case (reg_addr)
                `CPSM_OFS_CTRL: begin
                    s_nxt.rd_data[`CPSM_CTRL_HOLD] = s_r.sw_hold;
                end
                `CPSM_OFS_STATUS: begin
                    s_nxt.rd_data[`CPSM_STS_OV]    = is_ov(s_r.mode);
                    s_nxt.rd_data[`CPSM_STS_UV]    = is_uv(s_r.mode);
                    s_nxt.rd_data[`CPSM_STS_WARN]  = s_r.warn;
                    s_nxt.rd_data[`CPSM_STS_SLEEP] = s_r.sleep;
                    s_nxt.rd_data[`CPSM_STS_CHG]   = s_r.chg_en;
                    s_nxt.rd_data[`CPSM_STS_DIS]   = s_r.dis_en;
                    s_nxt.rd_data[`CPSM_STS_HOLD]  = s_r.hold;
                    s_nxt.rd_data[`CPSM_STS_PINS +: `CPSM_NPINS] = s_r.sync2;
                end
                `CPSM_OFS_EVENT: begin
                    s_nxt.rd_data[`CPSM_EVT_OV] = s_r.ov_evt;
                    s_nxt.rd_data[`CPSM_EVT_UV] = s_r.uv_evt;
                end
                default: begin
                    s_nxt.rd_data = 32'h0;
                end
            endcase
        end
    end

    always_ff @(posedge clk) begin
        if (srst) begin
            s_r <= RST;
        end else begin
            s_r <= s_nxt;
        end
    end

    assign reg_rd_data         = s_r.rd_data;
    assign high_cell_flag_n    = s_r.high_n;
    assign low_cell_flag_n     = s_r.low_n;
    assign charge_soon_warning = s_r.warn;
    assign charge_path_en      = s_r.chg_en;
    assign discharge_path_en   = s_r.dis_en;
    assign sleep_mode          = s_r.sleep;

    default clocking cb @(posedge clk);
    endclocking
    default disable iff (srst);

    sequence s_enter_uv;
        !is_uv(s_r.mode) ##1 is_uv(s_r.mode);
    endsequence

    sequence s_enter_ov;
        !is_ov(s_r.mode) ##1 is_ov(s_r.mode);
    endsequence

    sequence s_leave_ov;
        is_ov(s_r.mode) ##1 !is_ov(s_r.mode);
    endsequence

    sequence s_leave_uv;
        is_uv(s_r.mode) ##1 !is_uv(s_r.mode);
    endsequence

    a_ov_needs_qual: assert property (
        s_enter_ov |-> $past(ov_if.hit))
        else $error("overvoltage entered without qualification");

    a_uv_needs_qual: assert property (
        s_enter_uv |-> $past(uv_if.hit))
        else $error("undervoltage entered without qualification");

    a_hold_switch_off: assert property (
        s_r.sync2[`CPSM_PIN_HLD] |=> !charge_path_en && !discharge_path_en)
        else $error("switch on during assembly hold");

    a_warn_raise: assert property (
        any_warn && s_nxt.mode == cpsm_pkg::cpsm_normal
        |=> charge_soon_warning)
        else $error("warning missing for low cell");

    a_warn_drop_uv: assert property (
        s_enter_uv |-> !charge_soon_warning)
        else $error("warning still high in undervoltage");

    a_ov_flag_path: assert property (
        is_ov(s_r.mode) |-> !high_cell_flag_n && !charge_path_en)
        else $error("overvoltage flag or charge path wrong");

    a_uv_flag_path: assert property (
        is_uv(s_r.mode) |-> !low_cell_flag_n && !discharge_path_en)
        else $error("undervoltage flag or discharge path wrong");

    a_ov_discharge_only: assert property (
        s_r.mode == cpsm_pkg::cpsm_over && !s_r.hold
        |-> discharge_path_en && !charge_path_en)
        else $error("overcharged state must pass discharge only");

    a_uv_charge_only: assert property (
        s_r.mode == cpsm_pkg::cpsm_under && !s_r.hold
        |-> charge_path_en && !discharge_path_en)
        else $error("over-discharged state must pass charge only");

    a_ov_holds_until: assert property (
        s_r.mode == cpsm_pkg::cpsm_over && !all_ovr
        |=> is_ov(s_r.mode))
        else $error("left overvoltage before recovery");

    a_uv_holds_until: assert property (
        s_r.mode == cpsm_pkg::cpsm_under && any_warn
        |=> is_uv(s_r.mode))
        else $error("left undervoltage before recovery");

    a_both_blocked: assert property (
        s_r.mode == cpsm_pkg::cpsm_both
        |-> !high_cell_flag_n && !low_cell_flag_n
            && !charge_path_en && !discharge_path_en)
        else $error("mixed fault must block both ways");

    a_sleep_on_uv: assert property (
        s_enter_uv |-> sleep_mode ##1 (sleep_mode || $past(charger)
            || !is_uv(s_r.mode)))
        else $error("sleep not kept after undervoltage entry");

    a_ov_leave_recovered: assert property (
        s_leave_ov |-> $past(all_ovr))
        else $error("left overvoltage without both cells recovered");

    a_uv_leave_recovered: assert property (
        s_leave_uv |-> $past(!any_warn))
        else $error("left undervoltage without both cells recovered");

    a_sleep_only_uv: assert property (
        sleep_mode |-> is_uv(s_r.mode))
        else $error("sleep outside the undervoltage state");

    a_sw_hold_off: assert property (
        s_r.sw_hold |=> !charge_path_en && !discharge_path_en)
        else $error("switch on while software hold is set");

    a_ov_event_set: assert property (
        s_enter_ov |-> s_r.ov_evt)
        else $error("overvoltage entry not recorded");

    a_uv_event_set: assert property (
        s_enter_uv |-> s_r.uv_evt)
        else $error("undervoltage entry not recorded");
endmodule // cpsm_top
`default_nettype wire

// ===== cpsm_cells.sv
// Two series cells with ideal comparators and a charger presence line
`default_nettype none
module cpsm_cells #(
    parameter int OV_MV   = 4250,
    parameter int OVR_MV  = 3750,
    parameter int UV_MV   = 2500,
    parameter int WARN_MV = 3000
) (
    input  wire logic [12:0] mv0,
    input  wire logic [12:0] mv1,
    input  wire logic        on_charger,
    output logic      [1:0]  above_ov,
    output logic      [1:0]  below_ovr,
    output logic      [1:0]  below_uv,
    output logic      [1:0]  below_warn,
    output logic             charger_seen
);
    timeunit 1ns;
    timeprecision 1ps;
    // No comparator noise: each level change is a clean step
    assign above_ov     = {mv1 > OV_MV, mv0 > OV_MV};
    assign below_ovr    = {mv1 < OVR_MV, mv0 < OVR_MV};
    assign below_uv     = {mv1 < UV_MV, mv0 < UV_MV};
    assign below_warn   = {mv1 < WARN_MV, mv0 < WARN_MV};
    assign charger_seen = on_charger;
endmodule // cpsm_cells
`default_nettype wire

// ===== cpsm_top_bench.sv
// Self-checking bench of the cell protector against an integer model
`include "cpsm_map.svh"
`default_nettype none
module cpsm_top_bench;
    timeunit 1ns;
    timeprecision 1ps;
    localparam int OVD = 20;
    localparam int UVD = 10;
    localparam int OV_MV = 4250, OVR_MV = 3750, UV_MV = 2500, WR_MV = 3000;
    logic        clk, srst, chg, hold, wr, rd;
    logic [12:0] mv0, mv1;
    logic [1:0]  aov, bovr, buv, bwrn;
    logic        chs;
    logic [7:0]  addr;
    logic [31:0] wdat, rdat, got;
    logic        hi_n, lo_n, warn, cen, den, slp;
    int err_total, tests_run, cyc;
    int m_ov, m_uv, m_slp, m_ev, ctl;

    cpsm_cells cells (.mv0(mv0), .mv1(mv1), .on_charger(chg),
        .above_ov(aov), .below_ovr(bovr), .below_uv(buv),
        .below_warn(bwrn), .charger_seen(chs));
    cpsm_top #(.OV_DLY_CYC(OVD), .UV_DLY_CYC(UVD)) uut (.clk(clk),
        .srst(srst), .cell_above_ov(aov), .cell_below_ovr(bovr),
        .cell_below_uv(buv), .cell_below_warn(bwrn), .charger_seen(chs),
        .assembly_hold(hold), .reg_addr(addr), .reg_wr_data(wdat),
        .reg_wr_en(wr), .reg_rd_en(rd), .reg_rd_data(rdat),
        .high_cell_flag_n(hi_n), .low_cell_flag_n(lo_n),
        .charge_soon_warning(warn), .charge_path_en(cen),
        .discharge_path_en(den), .sleep_mode(slp));

    initial begin
        clk = 0;
        forever #4 clk = ~clk;
    end

    task automatic stop_test();
        $display("checks %0d mismatches %0d", tests_run, err_total);
        if (err_total == 0 && tests_run > 0)
            $display("No errors found");
        else
            $display("Errors were found");
        $finish;
    endtask

    always @(posedge clk) begin
        cyc <= cyc + 1;
        if (cyc == 20000) begin
            err_total++;
            $display("mismatch at %0t: run too long", $time);
            stop_test();
        end
    end

    task automatic chk_pin(logic g, logic e, string m);
        tests_run++;
        if (g !== e) begin
            err_total++;
            $display("mismatch at %0t: %s got %b", $time, m, g);
        end
    endtask

    task automatic chk_reg(logic [31:0] g, logic [31:0] e, string m);
        tests_run++;
        if (g !== e) begin
            err_total++;
            $display("mismatch at %0t: %s got %h exp %h", $time, m, g, e);
        end
    endtask

    task automatic wr_reg(logic [7:0] a, logic [31:0] d);
        @(posedge clk);
        wr <= 1;
        addr <= a;
        wdat <= d;
        @(posedge clk);
        wr <= 0;
    endtask

    // Data stand one cycle after the strobe, then fall back to zero
    task automatic rd_reg(logic [7:0] a, output logic [31:0] d);
        @(posedge clk);
        rd <= 1;
        addr <= a;
        @(posedge clk);
        rd <= 0;
        #1 d = rdat;
        @(posedge clk);
        #1 chk_reg(rdat, 32'h0, "read data held");
    endtask

    task automatic model_step();
        bit a_ov, a_uv;
        a_ov = mv0 > OV_MV || mv1 > OV_MV;
        a_uv = mv0 < UV_MV || mv1 < UV_MV;
        if (a_ov && m_ov == 0) m_ev |= 1;
        if (a_uv && m_uv == 0) begin
            m_ev |= 2;
            m_slp = 1;
        end
        if (a_ov) m_ov = 1;
        else if (mv0 < OVR_MV && mv1 < OVR_MV) m_ov = 0;
        if (a_uv) m_uv = 1;
        else if (mv0 >= WR_MV && mv1 >= WR_MV) m_uv = 0;
        if (chg || m_uv == 0) m_slp = 0;
    endtask

    task automatic settle_check();
        logic e_w, e_c, e_d;
        logic [31:0] e_s;
        repeat (OVD + 12) @(posedge clk);
        model_step();
        e_w = (mv0 < WR_MV || mv1 < WR_MV) && m_uv == 0;
        e_c = !hold && ctl == 0 && m_ov == 0;
        e_d = !hold && ctl == 0 && m_uv == 0;
        chk_pin(hi_n, m_ov == 0, "high flag");
        chk_pin(lo_n, m_uv == 0, "low flag");
        chk_pin(warn, e_w, "warning");
        chk_pin(cen, e_c, "charge path");
        chk_pin(den, e_d, "discharge path");
        chk_pin(slp, m_slp != 0, "sleep");
        e_s = {14'h0, hold, chs, bwrn, buv, bovr, aov, 1'b0,
               hold || ctl != 0, e_d, e_c, m_slp != 0, e_w,
               m_uv != 0, m_ov != 0};
        rd_reg(`CPSM_OFS_STATUS, got);
        chk_reg(got & 32'h0003ff7f, e_s, "status");
        rd_reg(`CPSM_OFS_EVENT, got);
        chk_reg(got, m_ev, "event");
        wr_reg(`CPSM_OFS_EVENT, 32'h3);
        m_ev = 0;
    endtask

    task automatic drive(int k, bit on);
        @(posedge clk);
        if (k == 0) mv0 <= on ? 13'd4400 : 13'd3600;
        else mv1 <= on ? 13'd2200 : 13'd3600;
    endtask

    task automatic hold_flag(int k, int n);
        repeat (n) begin
            @(posedge clk);
            #1 chk_pin(k == 0 ? hi_n : lo_n, 1'b1, "early flag");
        end
    endtask

    initial begin
        int d, n;
        srst = 1; chg = 0; hold = 0; wr = 0; rd = 0;
        mv0 = 13'd3600; mv1 = 13'd3600; addr = 8'h0; wdat = 32'h0;
        err_total = 0; tests_run = 0; cyc = 0;
        m_ov = 0; m_uv = 0; m_slp = 0; m_ev = 0; ctl = 0;
        void'($urandom(79));
        repeat (20) @(posedge clk);
        srst <= 0;
        settle_check();
        rd_reg(`CPSM_OFS_CTRL, got);
        chk_reg(got, 32'h0, "ctrl reset");
        rd_reg(8'h0c, got);
        chk_reg(got, 32'h0, "unmapped");
        $display("test reset and map done");
        for (int k = 0; k < 2; k++) begin
            d = k == 0 ? OVD : UVD;
            drive(k, 1);
            hold_flag(k, d - 4);
            drive(k, 0);
            hold_flag(k, 3);
            drive(k, 1);
            hold_flag(k, d);
            n = 0;
            while ((k == 0 ? hi_n : lo_n) !== 1'b0 && n < 8) begin
                @(posedge clk);
                #1 n++;
            end
            chk_pin(n < 8, 1'b1, "late flag");
            settle_check();
            drive(k, 0);
            settle_check();
            $display("test delay %0d done", k);
        end
        wr_reg(`CPSM_OFS_CTRL, 32'h1);
        ctl = 1;
        settle_check();
        wr_reg(`CPSM_OFS_CTRL, 32'h0);
        ctl = 0;
        hold <= 1;
        settle_check();
        hold <= 0;
        $display("test switch hold done");
        mv0 <= 13'd4400;
        mv1 <= 13'd2200;
        settle_check();
        chg <= 1;
        settle_check();
        mv0 <= 13'd3600;
        mv1 <= 13'd3600;
        settle_check();
        $display("test mixed cells done");
        repeat (14) begin
            mv0 <= 13'($urandom_range(4600, 2000));
            mv1 <= 13'($urandom_range(4600, 2000));
            chg <= 1'($urandom % 2);
            hold <= ($urandom % 4) == 0;
            settle_check();
        end
        $display("test random levels done");
        stop_test();
    end
endmodule // cpsm_top_bench
`default_nettype wire
